// [rtl/smii_map.svh]
// ==========================================================
// Purpose: offsets, field positions, reset values, counts
// Assumes: included by bare name
// Notes:   definitions only
`ifndef SMII_MAP_SVH
`define SMII_MAP_SVH

// ==========================================================
// link timing
`define SMII_REF_KHZ      125000
`define SMII_SYNC_KHZ     12500
`define SMII_SEG_BITS     (`SMII_REF_KHZ / `SMII_SYNC_KHZ)
`define SMII_SEG_REPEAT   10
`define SMII_STRAP_MODE   3'h2

// ==========================================================
// register byte addresses
`define SMII_ADR_CTRL     8'h00
`define SMII_ADR_STAT     8'h04
`define SMII_ADR_TXD      8'h08
`define SMII_ADR_RXD      8'h0C

// ==========================================================
// fields and reset values
`define SMII_CTRL_RST     8'h00
`define SMII_STAT_OVR     2
`define SMII_STAT_FILL    1'h1

`endif

// [rtl/smii_pkg.sv]
// ==========================================================
// Purpose: shared types of the serial data interface
// Assumes: nothing
// Notes:   bit 0 of each segment and status struct is sent or taken first
`default_nettype none

package smii_pkg;

	// status carried in receive segments, bit 0 first
	typedef struct packed {
		logic false_crs;
		logic nib_ok;
		logic jabber;
		logic link;
		logic duplex;
		logic speed;
		logic prev_err;
	} rx_stat_t;

	typedef struct packed {
		logic     carrier;
		rx_stat_t st;
	} rx_cfg_t;

	// status seen in transmit segments
	typedef struct packed {
		logic jabber;
		logic link;
		logic duplex;
		logic speed;
		logic force_err;
	} tx_stat_t;

	// one ten-bit segment, flag on the wire first
	typedef struct packed {
		logic [7:0] data;
		logic       en;
		logic       flag;
	} seg_t;

	typedef struct packed {
		logic       er;
		logic [7:0] data;
	} tx_byte_t;

endpackage : smii_pkg

`default_nettype wire

// [rtl/bit_sync.sv]
// ==========================================================
// Purpose: two-flop level synchroniser, per bit
// Assumes: each bit is a level, held longer than two clocks
// Notes:   no reset, so straps survive the reset edge
`default_nettype none

module bit_sync #(
	parameter int W = 1
) (
	// destination clock
	input  wire logic         clk_i,
	// levels
	input  wire logic [W-1:0] d_i,
	output var  logic [W-1:0] q_o
);

	// ==========================================================
	// per-bit chain
	for (genvar g = 0; g < W; g++) begin : g_bit
		logic [1:0] st_reg;
		always_ff @(posedge clk_i) begin
			st_reg <= {st_reg[0], d_i[g]};
		end
		assign q_o[g] = st_reg[1];
	end

endmodule : bit_sync

`default_nettype wire

// [rtl/smii_phy_data_interface.sv]
// ==========================================================
// Purpose: serial MII data path of the transceiver, MAC side
// Assumes: ref_clk_i free running; MAC drives sync_i, tx_i
// Notes:   one byte each way crosses by toggle; only the byte to the MAC is acknowledged
//
// Decided for this implementation: the address map and the Wishbone slave port.
`default_nettype none

`include "smii_map.svh"

module smii_phy_data_interface
	import smii_pkg::*;
(
	// system clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output var  logic [31:0] wb_dat_o,
	output var  logic        wb_ack_o,
	// mode straps
	input  wire logic [2:0]  mode_strap_i,
	// serial link
	input  wire logic        ref_clk_i,
	input  wire logic        sync_i,
	input  wire logic        tx_i,
	output var  logic        rx_o
);

	localparam logic [3:0] SEG_N = 4'(`SMII_SEG_BITS);
	localparam logic [3:0] REP_N = 4'(`SMII_SEG_REPEAT);

	// ==========================================================
	// crossings
	logic [2:0] strap_s;
	logic       lrst;
	tx_stat_t   mac_st_reg;
	tx_stat_t   mac_st_s;
	logic       tx_tgl_reg;
	logic       tx_tgl_s;
	logic       ack_tgl_reg;
	logic       ack_s;
	rx_cfg_t    cfg_reg;
	rx_cfg_t    lcfg;
	logic       smii_on_reg;
	logic       lmode;
	logic       req_tgl_reg;
	logic       lreq;

	bit_sync #(.W(3)) u_strap (
		.clk_i (clk_i),
		.d_i   (mode_strap_i),
		.q_o   (strap_s)
	);

	bit_sync #(.W(1)) u_lrst (
		.clk_i (ref_clk_i),
		.d_i   (rst_i),
		.q_o   (lrst)
	);

	// status bits are quasi-static, so per-bit sync is enough
	bit_sync #(.W(7)) u_to_sys (
		.clk_i (clk_i),
		.d_i   ({mac_st_reg, tx_tgl_reg, ack_tgl_reg}),
		.q_o   ({mac_st_s, tx_tgl_s, ack_s})
	);

	bit_sync #(.W(10)) u_to_link (
		.clk_i (ref_clk_i),
		.d_i   ({cfg_reg, smii_on_reg, req_tgl_reg}),
		.q_o   ({lcfg, lmode, lreq})
	);

	// ==========================================================
	// link: input sampling and bit counter
	logic       sync_q_reg;
	logic       tx_q_reg;
	logic [3:0] bcnt_reg;
	logic [9:0] sh_reg;
	logic [3:0] rep_reg;
	seg_t       rseg_reg;
	tx_byte_t   tx_hold_reg;
	logic [7:0] rxb_reg;
	seg_t       tx_seg;
	seg_t       stat_seg;
	seg_t       byte_seg;
	seg_t       rseg_next;
	logic       lspeed;
	logic       fresh;
	logic       pend;
	logic       take;
	logic       seg_done;
	logic       tx_pick;

	always_ff @(posedge ref_clk_i) begin
		if (lrst) begin
			sync_q_reg <= 1'h0;
			tx_q_reg   <= 1'h0;
			sh_reg     <= 10'h000;
			bcnt_reg   <= SEG_N;
		end else begin
			sync_q_reg <= sync_i;
			tx_q_reg   <= tx_i;
			sh_reg     <= {tx_q_reg, sh_reg[9:1]};
			if (sync_q_reg) begin
				bcnt_reg <= 4'h1;
			end else if (bcnt_reg != SEG_N) begin
				bcnt_reg <= bcnt_reg + 4'h1;
			end
		end
	end

	// a group of ten segments shares one byte at 10M
	always_ff @(posedge ref_clk_i) begin
		if (lrst) begin
			rep_reg <= REP_N - 4'h1;
		end else if (sync_q_reg) begin
			rep_reg <= fresh ? 4'h0 : rep_reg + 4'h1;
		end
	end

	assign lspeed   = lcfg.st.speed;
	assign fresh    = lspeed || (rep_reg == REP_N - 4'h1);
	assign pend     = lreq != ack_tgl_reg;
	assign take     = sync_q_reg && fresh && pend && lmode;
	assign tx_seg   = {tx_q_reg, sh_reg[9:1]};
	assign seg_done = lmode && !sync_q_reg && (bcnt_reg == SEG_N - 4'h1);
	assign tx_pick  = seg_done && (lspeed || rep_reg == 4'h0);

	// ==========================================================
	// link: receive segment builder
	always_comb begin
		stat_seg.data = {`SMII_STAT_FILL, lcfg.st};
		stat_seg.en   = 1'h0;
		stat_seg.flag = lcfg.carrier;
		byte_seg.data = rxb_reg;
		byte_seg.en   = 1'h1;
		byte_seg.flag = 1'h1;
		if (!fresh) begin
			rseg_next = rseg_reg;
		end else if (pend) begin
			rseg_next = byte_seg;
		end else begin
			rseg_next = stat_seg;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (lrst) begin
			rseg_reg    <= '0;
			rx_o        <= 1'h0;
			ack_tgl_reg <= 1'h0;
		end else if (!lmode) begin
			rx_o <= 1'h0;
		end else if (sync_q_reg) begin
			rseg_reg <= rseg_next;
			rx_o     <= rseg_next.flag;
			if (take) begin
				ack_tgl_reg <= lreq;
			end
		end else if (bcnt_reg < SEG_N) begin
			rx_o <= rseg_reg[bcnt_reg];
		end else begin
			rx_o <= 1'h0;
		end
	end

	// ==========================================================
	// link: transmit segment decoder
	always_ff @(posedge ref_clk_i) begin
		if (lrst) begin
			tx_hold_reg <= '0;
			tx_tgl_reg  <= 1'h0;
			mac_st_reg  <= '0;
		end else if (tx_pick) begin
			if (tx_seg.en) begin
				tx_hold_reg.er   <= tx_seg.flag;
				tx_hold_reg.data <= tx_seg.data;
				tx_tgl_reg       <= ~tx_tgl_reg;
			end else begin
				mac_st_reg <= tx_stat_t'(tx_seg.data[4:0]);
			end
		end
	end

	// ==========================================================
	// system: strap capture
	logic caught_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			caught_reg  <= 1'h0;
			smii_on_reg <= 1'h0;
		end else if (!caught_reg) begin
			caught_reg  <= 1'h1;
			smii_on_reg <= strap_s == `SMII_STRAP_MODE;
		end
	end

	// ==========================================================
	// system: wishbone decode
	logic acc;
	logic wr;
	logic rd;
	logic wr0;

	assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr  = acc && wb_we_i;
	assign rd  = acc && !wb_we_i;
	assign wr0 = wr && wb_sel_i[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'h0;
		end else begin
			wb_ack_o <= acc;
		end
	end

	// ==========================================================
	// system: received byte from the MAC
	tx_byte_t txd_reg;
	logic     tx_seen_reg;
	logic     avail_reg;
	logic     ovr_reg;
	logic     tx_new;
	logic     rd_txd;
	logic     ovr_clr;

	assign tx_new  = tx_tgl_s != tx_seen_reg;
	assign rd_txd  = rd && (wb_adr_i == `SMII_ADR_TXD);
	assign ovr_clr = wr0 && (wb_adr_i == `SMII_ADR_STAT) && wb_dat_i[`SMII_STAT_OVR];

	// hold register is stable: the link waits a segment per byte
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_seen_reg <= 1'h0;
			txd_reg     <= '0;
		end else if (tx_new) begin
			tx_seen_reg <= tx_tgl_s;
			txd_reg     <= tx_hold_reg;
		end
	end

	// a new byte wins over a read or clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			avail_reg <= 1'h0;
			ovr_reg   <= 1'h0;
		end else begin
			avail_reg <= tx_new || (avail_reg && !rd_txd);
			ovr_reg   <= (tx_new && avail_reg && !rd_txd) || (ovr_reg && !ovr_clr);
		end
	end

	// ==========================================================
	// system: control and byte to the MAC
	logic busy;

	assign busy = req_tgl_reg != ack_s;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg <= rx_cfg_t'(`SMII_CTRL_RST);
		end else if (wr0 && (wb_adr_i == `SMII_ADR_CTRL)) begin
			cfg_reg <= rx_cfg_t'(wb_dat_i[7:0]);
		end
	end

	// writes while a byte is still in flight are dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rxb_reg     <= 8'h00;
			req_tgl_reg <= 1'h0;
		end else if (wr0 && (wb_adr_i == `SMII_ADR_RXD) && !busy) begin
			rxb_reg     <= wb_dat_i[7:0];
			req_tgl_reg <= ~req_tgl_reg;
		end
	end

	// ==========================================================
	// system: read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0;
		end else if (rd) begin
			case (wb_adr_i)
				`SMII_ADR_CTRL: wb_dat_o <= {24'h0, cfg_reg};
				`SMII_ADR_STAT: begin
					wb_dat_o <= {19'h0, mac_st_s, 4'h0, busy, ovr_reg, avail_reg, smii_on_reg};
				end
				`SMII_ADR_TXD:  wb_dat_o <= {23'h0, txd_reg};
				default:        wb_dat_o <= 32'h0;
			endcase
		end
	end

	// ==========================================================
	// checks
	property p_seg_len;
		@(posedge ref_clk_i) disable iff (lrst)
		sync_q_reg ##1 !sync_q_reg [*8] |=> bcnt_reg == 4'h9;
	endproperty
	a_seg_len: assert property (p_seg_len)
		else $error("segment bit count wrong");

	property p_rx_first;
		@(posedge ref_clk_i) disable iff (lrst)
		sync_q_reg && lmode |=> rx_o == rseg_reg.flag;
	endproperty
	a_rx_first: assert property (p_rx_first)
		else $error("receive flag bit not first");

	property p_rx_byte;
		@(posedge ref_clk_i) disable iff (lrst)
		take |=> rseg_reg.en && rseg_reg.flag && rseg_reg.data == $past(rxb_reg);
	endproperty
	a_rx_byte: assert property (p_rx_byte)
		else $error("receive byte segment wrong");

	property p_rx_stat;
		@(posedge ref_clk_i) disable iff (lrst)
		sync_q_reg && lmode && fresh && !pend
		|=> !rseg_reg.en && rseg_reg.data == {1'h1, $past(lcfg.st)};
	endproperty
	a_rx_stat: assert property (p_rx_stat)
		else $error("receive status segment wrong");

	property p_rx_repeat;
		@(posedge ref_clk_i) disable iff (lrst)
		sync_q_reg && lmode && !fresh |=> $stable(rseg_reg);
	endproperty
	a_rx_repeat: assert property (p_rx_repeat)
		else $error("receive segment not repeated");

	property p_tx_skip;
		@(posedge ref_clk_i) disable iff (lrst)
		seg_done && !lspeed && rep_reg != 4'h0 |=> $stable(tx_tgl_reg);
	endproperty
	a_tx_skip: assert property (p_tx_skip)
		else $error("repeated transmit segment taken");

	property p_tx_byte;
		@(posedge ref_clk_i) disable iff (lrst)
		tx_pick && tx_seg.en
		|=> tx_tgl_reg != $past(tx_tgl_reg)
			&& tx_hold_reg == $past({tx_seg.flag, tx_seg.data});
	endproperty
	a_tx_byte: assert property (p_tx_byte)
		else $error("transmit byte not captured");

	property p_tx_stat;
		@(posedge ref_clk_i) disable iff (lrst)
		tx_pick && !tx_seg.en |=> mac_st_reg == $past(tx_seg.data[4:0]);
	endproperty
	a_tx_stat: assert property (p_tx_stat)
		else $error("transmit status not captured");

	property p_strap;
		@(posedge clk_i) disable iff (rst_i)
		$rose(caught_reg) |-> smii_on_reg == ($past(strap_s) == 3'h2);
	endproperty
	a_strap: assert property (p_strap)
		else $error("strap mode capture wrong");

endmodule : smii_phy_data_interface

`default_nettype wire

// [test/mac_model.sv]
// ==========================================================
// Purpose: MAC end of the serial link, behavioural
// Assumes: ref_clk_i continuous
// Notes:   seg_i is latched whole at each segment start
`default_nettype none

module mac_model
	import smii_pkg::*;
(
	// link
	input  wire logic ref_clk_i,
	output var  logic sync_o,
	output var  logic tx_o,
	input  wire logic rx_i,
	// bench side
	input  wire seg_t seg_i,
	output var  int   tx_cnt_o,
	output var  int   rx_cnt_o,
	output var  seg_t rx_seg_o
);
	logic [3:0] ph;
	seg_t       cur;
	seg_t       acc;
	logic       col;

	initial begin
		ph       = 4'h0;
		sync_o   = 1'b0;
		tx_o     = 1'b0;
		cur      = '0;
		acc      = '0;
		rx_seg_o = '0;
		tx_cnt_o = 0;
		rx_cnt_o = 0;
	end

	// ==========================================================
	// sync every ten clocks, tx bit k in cycle k
	always @(posedge ref_clk_i) begin
		ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
		sync_o <= (ph == 4'h9);
		if (ph == 4'h9) begin
			cur <= seg_i;
			tx_o <= seg_i[0];
			tx_cnt_o <= tx_cnt_o + 1;
		end else begin
			tx_o <= cur[ph + 4'h1];
		end
		// rx bit k is sampled two clocks after sync plus k
		acc[(int'(ph) + 8) % 10] <= rx_i;
		if (ph == 4'h2) begin
			rx_seg_o <= acc;
			rx_cnt_o <= rx_cnt_o + 1;
		end
	end

	assign col = acc.flag & cur.en;
endmodule : mac_model

`default_nettype wire

// [test/testbench.sv]
// ==========================================================
// Purpose: self-checking bench of the serial data interface
// Assumes: link clock unrelated in phase to clk_i
// Notes:   reset is held over six link clocks, as the link needs
`default_nettype none

module testbench
	import smii_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk_i;
	logic        ref_clk;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = '0;
	logic [3:0]  sel = '0;
	logic [31:0] dat = '0;
	logic [2:0]  strap = 3'h2;
	logic [31:0] dat_o;
	logic        ack;
	logic        sync;
	logic        tx;
	logic        rx;
	seg_t        mac_seg = '0;
	seg_t        rx_seg;
	int          tx_cnt;
	int          rx_cnt;
	int          failures = 0;
	int          tests_run = 0;
	logic [31:0] st = 32'h3B;

	smii_phy_data_interface u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .mode_strap_i(strap), .ref_clk_i(ref_clk),
		.sync_i(sync), .tx_i(tx), .rx_o(rx));
	mac_model u_mac (.ref_clk_i(ref_clk), .sync_o(sync), .tx_o(tx), .rx_i(rx),
		.seg_i(mac_seg), .tx_cnt_o(tx_cnt), .rx_cnt_o(rx_cnt), .rx_seg_o(rx_seg));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		ref_clk = 1'b0;
		#3;
		forever #62.5 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// helpers
	function automatic logic [31:0] rnd();
		st ^= st << 13;
		st ^= st >> 17;
		st ^= st << 5;
		return st;
	endfunction : rnd
	function automatic seg_t idle_seg(logic [7:0] c);
		return '{data: {1'b1, c[6:0]}, en: 1'b0, flag: c[7]};
	endfunction : idle_seg
	task automatic fail(string m);
		failures++;
		$display("ERROR %0t %s", $time, m);
	endtask : fail
	task automatic chk32(logic [31:0] g, logic [31:0] e);
		tests_run++;
		if (g !== e) fail("register value");
	endtask : chk32
	task automatic chk_seg(seg_t g, seg_t e);
		tests_run++;
		if (g !== e) fail("receive segment");
	endtask : chk_seg
	task automatic report_and_stop();
		if (failures == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// wishbone classic, waits for ack without a bound
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s,
		output logic [31:0] q);
		@(posedge clk_i);
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
		// only the watchdog ends a wait for ack
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = dat_o;
		{cyc, stb} <= 2'b00;
	endtask : wb
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s);
		logic [31:0] q;
		wb(1'b1, a, d, s, q);
	endtask : wr
	task automatic rd(logic [7:0] a, output logic [31:0] q);
		wb(1'b0, a, 32'h0, 4'hF, q);
	endtask : rd

	// ==========================================================
	// link waits, counted in segments seen by the mac
	task automatic wait_rx(output seg_t s);
		int c;
		int n;
		c = rx_cnt;
		n = 0;
		while (rx_cnt == c && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 400) fail("no rx segment");
		s = rx_seg;
	endtask : wait_rx
	task automatic wait_data(output seg_t s);
		int n;
		n = 0;
		do begin
			wait_rx(s);
			n++;
		end while (s.en !== 1'b1 && n < 25);
	endtask : wait_data
	task automatic send_tx(logic [7:0] b, logic er, int k);
		seg_t s;
		seg_t t;
		s = mac_seg;
		// align to a receive update so exactly k segments carry the byte
		wait_rx(t);
		mac_seg <= '{data: b, en: 1'b1, flag: er};
		repeat (k) wait_rx(t);
		mac_seg <= s;
	endtask : send_tx
	task automatic tx_check(logic [7:0] b, logic er);
		logic [31:0] q;
		seg_t        t;
		repeat (3) wait_rx(t);
		rd(8'h04, q);
		chk32(q & 32'h6, 32'h2);
		rd(8'h08, q);
		chk32(q, {23'h0, er, b});
	endtask : tx_check

	// ==========================================================
	// main sequence
	initial begin
		seg_t        s;
		logic [31:0] q;
		logic [7:0]  c;
		logic [7:0]  b;
		logic [4:0]  m;
		repeat (6) @(posedge ref_clk);
		@(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h04, q);
		chk32(q & 32'h1, 32'h1);
		rd(8'h10, q);
		chk32(q, 32'h0);
		for (int i = 0; i < 3; i++) begin
			c = 8'(rnd()) | 8'h02;
			m = 5'(rnd());
			mac_seg <= '{data: {3'b111, m}, en: 1'b0, flag: 1'b0};
			wr(8'h00, c, 4'h1);
			wr(8'h00, ~c, 4'hE);
			rd(8'h00, q);
			chk32(q, {24'h0, c});
			repeat (3) wait_rx(s);
			chk_seg(s, idle_seg(c));
			rd(8'h04, q);
			chk32(q & 32'h1F00, {19'h0, m, 8'h00});
		end
		// 100M: one byte per segment each way
		for (int i = 0; i < 4; i++) begin
			b = 8'(rnd());
			send_tx(b, b[3], 1);
			tx_check(b, b[3]);
			b = 8'(rnd());
			wr(8'h0C, b, 4'h1);
			wait_data(s);
			chk_seg(s, '{data: b, en: 1'b1, flag: 1'b1});
		end
		// 10M: tenfold repeats, one byte taken per group
		c = 8'(rnd()) & 8'hFD;
		wr(8'h00, c, 4'h1);
		for (int i = 0; i < 2; i++) begin
			b = 8'(rnd());
			send_tx(b, b[0], 10);
			tx_check(b, b[0]);
			b = 8'(rnd());
			wr(8'h0C, b, 4'h1);
			wait_data(s);
			repeat (9) begin
				chk_seg(s, '{data: b, en: 1'b1, flag: 1'b1});
				wait_rx(s);
			end
			chk_seg(s, '{data: b, en: 1'b1, flag: 1'b1});
			wait_rx(s);
			chk_seg(s, idle_seg(c));
		end
		// other strap value keeps the link silent
		strap <= 3'h1;
		rst_i <= 1'b1;
		repeat (6) @(posedge ref_clk);
		@(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h04, q);
		chk32(q & 32'h1, 32'h0);
		repeat (3) wait_rx(s);
		chk_seg(s, '0);
		report_and_stop();
	end

	initial begin
		#400000;
		failures++;
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire
